// File: design/usbd_fifo.sv
// synchronous fifo with a registered head word
`default_nettype none
module usbd_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic out_reg_valid;

    wire push = in_valid && in_ready;
    wire load = (!out_reg_valid || out_ready) && (count != '0);
    wire [CW-1:0] next_count = count + CW'(push) - CW'(load);

    // head word sits in its own flop so the drain side sees a registered output
    assign out_valid = out_reg_valid;
    assign full = (count == CW'(DEPTH));
    assign in_ready = !full;
    assign empty = !out_reg_valid && (count == '0);

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_reg_valid <= 1'b0;
            out_data <= '0;
        end else begin
            count <= next_count;
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (load) begin
                out_data <= mem[rd_ptr];
                out_reg_valid <= 1'b1;
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end else if (out_ready) begin
                out_reg_valid <= 1'b0;
            end
        end
    end
endmodule : usbd_fifo
`default_nettype wire

// File: design/usbd_pkg.sv
// types shared by the usb device command and transfer port
`default_nettype none
package usbd_pkg;
    typedef logic [9:0] usbd_len_t;
    typedef logic [3:0] usbd_ep_t;
    typedef enum logic [1:0] {usbd_rx_idle, usbd_rx_len, usbd_rx_word, usbd_rx_ready} usbd_rx_e;
endpackage : usbd_pkg
`default_nettype wire

// File: design/usbd_port.sv
// register port of the usb device: engine commands and slave-mode endpoint transfers
// Function
// - forward command word, then flag slot empty
// - bits 15:8 phase, 23:16 code or data
// - command register reads back as zero
// - engine result byte in bits 7:0, flag
// - each receive read but the last fetches next little-endian word
// - transmit write stores word, low byte first
// - remaining receive bytes kept in bits 9:0
// - receive count zero sets receive done flag
// - isochronous bad packet transferred, valid bit clear
// - valid bit shows invalid non-isochronous data
// - transmit count minus four, zero sets flag
// - last receive word clears read enable
`include "usbd_regs.svh"
`default_nettype none
module usbd_port #(
    parameter int FIFO_DEPTH = `USBD_TX_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic cmd_valid,
    output logic [7:0] cmd_phase,
    output logic [7:0] cmd_code_wdata,
    input wire logic cmd_done,
    input wire logic result_valid,
    input wire logic [7:0] result_data,
    output logic rx_len_req,
    output logic rx_word_req,
    output usbd_pkg::usbd_ep_t rx_ep,
    input wire logic rx_len_valid,
    input wire usbd_pkg::usbd_len_t rx_len_bytes,
    input wire logic rx_len_ok,
    input wire logic rx_word_valid,
    input wire logic [31:0] rx_word_data,
    output logic tx_word_valid,
    input wire logic tx_word_ready,
    output logic [31:0] tx_word_data,
    output usbd_pkg::usbd_ep_t tx_word_ep
);
    import usbd_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // a word moves at most four bytes; a short tail must not wrap the count
    function automatic usbd_len_t bytes_after_word(input usbd_len_t left);
        bytes_after_word = (left > `USBD_BYTES_PER_WORD) ? left - `USBD_BYTES_PER_WORD : '0;
    endfunction : bytes_after_word

    function automatic logic phase_known(input logic [7:0] phase);
        phase_known = (phase == `USBD_PHASE_WRITE) || (phase == `USBD_PHASE_READ)
            || (phase == `USBD_PHASE_COMMAND);
    endfunction : phase_known

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic flag_cmd_empty;
    logic flag_result;
    logic flag_rx_done;
    logic flag_tx_done;
    logic [7:0] result_byte;
    logic rd_en;
    logic wr_en;
    usbd_ep_t ep_sel;
    usbd_rx_e rx_state;
    usbd_len_t rx_left;
    logic rx_dv;
    logic [31:0] rx_word;
    usbd_len_t tx_left;
    logic fifo_in_ready;
    logic fifo_full;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire hit_clear = reg_write && (reg_addr == `USBD_CLEAR_ADDR);
    wire hit_cmd = reg_write && (reg_addr == `USBD_CMD_ADDR);
    wire hit_ctrl = reg_write && (reg_addr == `USBD_CTRL_ADDR);
    wire hit_txlen = reg_write && (reg_addr == `USBD_TXLEN_ADDR);
    wire hit_txdata = reg_write && (reg_addr == `USBD_TXDATA_ADDR);
    wire hit_rxdata = reg_read && (reg_addr == `USBD_RXDATA_ADDR);

    wire [7:0] wr_phase = reg_wdata[`USBD_CMD_PHASE_LSB +: 8];
    wire [7:0] wr_code = reg_wdata[`USBD_CMD_CODE_LSB +: 8];
    wire wr_rd_en = reg_wdata[`USBD_CTRL_RD_BIT];
    wire wr_wr_en = reg_wdata[`USBD_CTRL_WR_BIT];
    wire [3:0] wr_ep = reg_wdata[`USBD_CTRL_EP_LSB +: `USBD_EP_W];

    // ----------------------------------------------------------------
    // event terms
    // ----------------------------------------------------------------
    // an unknown phase never reaches the engine and completes at once
    wire cmd_refused = hit_cmd && !phase_known(wr_phase);
    wire cmd_finished = (cmd_valid && cmd_done) || cmd_refused;
    wire rx_take = hit_rxdata && (rx_state == usbd_rx_ready) && rd_en;
    wire [9:0] rx_left_next = bytes_after_word(rx_left);
    wire rx_len_zero = (rx_state == usbd_rx_len) && rx_len_valid && (rx_len_bytes == '0);
    wire rx_end = (rx_take && (rx_left_next == '0)) || rx_len_zero;
    // a full fifo refuses the word; the status shows it so software can back off
    wire tx_take = hit_txdata && wr_en && fifo_in_ready;
    wire [9:0] tx_left_next = bytes_after_word(tx_left);
    wire tx_end = tx_take && (tx_left_next == '0);
    wire rx_start = hit_ctrl && wr_rd_en && !rd_en;
    wire [31:0] clear_bits = hit_clear ? reg_wdata : '0;

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [31:0] status_word = (32'(flag_cmd_empty) << `USBD_FLAG_CMD_EMPTY)
        | (32'(flag_result) << `USBD_FLAG_RESULT)
        | (32'(flag_rx_done) << `USBD_FLAG_RX_DONE)
        | (32'(flag_tx_done) << `USBD_FLAG_TX_DONE)
        | (32'(fifo_full) << `USBD_FLAG_TX_FULL);
    wire [31:0] rxlen_word = {21'h000000, rx_dv, rx_left};
    wire [31:0] ctrl_word = {26'h0000000, ep_sel, wr_en, rd_en};
    // write-only registers and unmapped addresses read as zero
    wire [31:0] next_rdata = (reg_addr == `USBD_STATUS_ADDR) ? status_word
        : (reg_addr == `USBD_RESULT_ADDR) ? {24'h000000, result_byte}
        : (reg_addr == `USBD_RXDATA_ADDR) ? rx_word
        : (reg_addr == `USBD_RXLEN_ADDR) ? rxlen_word
        : (reg_addr == `USBD_TXLEN_ADDR) ? {22'h000000, tx_left}
        : (reg_addr == `USBD_CTRL_ADDR) ? ctrl_word
        : `USBD_RESET_WORD;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            reg_rdata <= `USBD_RESET_WORD;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= `USBD_RESET_WORD;
        end
    end

    // ----------------------------------------------------------------
    // sticky flags: a set in the clearing cycle wins
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            flag_cmd_empty <= 1'b0;
            flag_result <= 1'b0;
            flag_rx_done <= 1'b0;
            flag_tx_done <= 1'b0;
        end else begin
            flag_cmd_empty <= cmd_finished
                || (flag_cmd_empty && !clear_bits[`USBD_FLAG_CMD_EMPTY]);
            flag_result <= result_valid || (flag_result && !clear_bits[`USBD_FLAG_RESULT]);
            flag_rx_done <= rx_end || (flag_rx_done && !clear_bits[`USBD_FLAG_RX_DONE]);
            flag_tx_done <= tx_end || (flag_tx_done && !clear_bits[`USBD_FLAG_TX_DONE]);
        end
    end

    // ----------------------------------------------------------------
    // engine command slot
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cmd_valid <= 1'b0;
            cmd_phase <= 8'h00;
            cmd_code_wdata <= 8'h00;
        end else if (hit_cmd && !cmd_refused) begin
            cmd_valid <= 1'b1;
            cmd_phase <= wr_phase;
            cmd_code_wdata <= wr_code;
        end else if (cmd_done) begin
            cmd_valid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            result_byte <= 8'h00;
        end else if (result_valid) begin
            result_byte <= result_data;
        end
    end

    // ----------------------------------------------------------------
    // transfer control
    // ----------------------------------------------------------------
    // a software write to the control word overrides the hardware clears
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rd_en <= 1'b0;
            wr_en <= 1'b0;
            ep_sel <= '0;
        end else if (hit_ctrl) begin
            rd_en <= wr_rd_en;
            wr_en <= wr_wr_en;
            ep_sel <= wr_ep;
        end else begin
            if (rx_end) begin
                rd_en <= 1'b0;
            end
            if (tx_end) begin
                wr_en <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rx_ep <= '0;
        end else if (hit_ctrl) begin
            rx_ep <= wr_ep;
        end
    end

    // ----------------------------------------------------------------
    // receive: fetch length, then one word ahead of each read
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rx_state <= usbd_rx_idle;
            rx_len_req <= 1'b0;
            rx_word_req <= 1'b0;
            rx_left <= '0;
            rx_dv <= 1'b0;
            rx_word <= `USBD_RESET_WORD;
        end else begin
            rx_len_req <= 1'b0;
            rx_word_req <= 1'b0;
            if (hit_ctrl && !wr_rd_en) begin
                // dropping read enable abandons the packet; data stays in the buffer
                rx_state <= usbd_rx_idle;
            end else begin
                unique case (rx_state)
                    usbd_rx_idle: begin
                        if (rx_start) begin
                            rx_len_req <= 1'b1;
                            rx_state <= usbd_rx_len;
                        end
                    end
                    usbd_rx_len: begin
                        if (rx_len_valid) begin
                            rx_left <= rx_len_bytes;
                            rx_dv <= rx_len_ok;
                            if (rx_len_bytes == '0) begin
                                rx_state <= usbd_rx_idle;
                            end else begin
                                rx_word_req <= 1'b1;
                                rx_state <= usbd_rx_word;
                            end
                        end
                    end
                    usbd_rx_word: begin
                        if (rx_word_valid) begin
                            rx_word <= rx_word_data;
                            rx_state <= usbd_rx_ready;
                        end
                    end
                    usbd_rx_ready: begin
                        if (rx_take) begin
                            rx_left <= rx_left_next;
                            if (rx_left_next == '0) begin
                                rx_state <= usbd_rx_idle;
                            end else begin
                                rx_word_req <= 1'b1;
                                rx_state <= usbd_rx_word;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // transmit: count down and queue words for the endpoint buffer
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            tx_left <= '0;
        end else if (hit_txlen) begin
            tx_left <= reg_wdata[`USBD_LEN_W-1:0];
        end else if (tx_take) begin
            tx_left <= tx_left_next;
        end
    end

    usbd_fifo #(
        .WIDTH(36),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_valid(tx_take),
        .in_ready(fifo_in_ready),
        .in_data({ep_sel, reg_wdata}),
        .out_valid(tx_word_valid),
        .out_ready(tx_word_ready),
        .out_data({tx_word_ep, tx_word_data}),
        .full(fifo_full),
        .empty()
    );
endmodule : usbd_port
`default_nettype wire

// File: design/usbd_regs.svh
// register offsets, field positions and codes of the usb device command and transfer port
`ifndef USBD_REGS_SVH
`define USBD_REGS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define USBD_STATUS_ADDR 32'h40020000
`define USBD_CLEAR_ADDR 32'h40020008
`define USBD_CMD_ADDR 32'h40020010
`define USBD_RESULT_ADDR 32'h40020014
`define USBD_RXDATA_ADDR 32'h40020018
`define USBD_TXDATA_ADDR 32'h4002001C
`define USBD_RXLEN_ADDR 32'h40020020
`define USBD_TXLEN_ADDR 32'h40020024
`define USBD_CTRL_ADDR 32'h40020028

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define USBD_CMD_PHASE_LSB 8
`define USBD_CMD_CODE_LSB 16
`define USBD_LEN_W 10
`define USBD_RXLEN_VALID_BIT 10
`define USBD_CTRL_RD_BIT 0
`define USBD_CTRL_WR_BIT 1
`define USBD_CTRL_EP_LSB 2
`define USBD_EP_W 4
`define USBD_FLAG_CMD_EMPTY 10
`define USBD_FLAG_RESULT 11
`define USBD_FLAG_RX_DONE 12
`define USBD_FLAG_TX_DONE 13
`define USBD_FLAG_TX_FULL 16

// ----------------------------------------------------------------
// phase codes, reset values, sizes
// ----------------------------------------------------------------
`define USBD_PHASE_WRITE 8'h01
`define USBD_PHASE_READ 8'h02
`define USBD_PHASE_COMMAND 8'h05
`define USBD_RESET_WORD 32'h00000000
`define USBD_BYTES_PER_WORD 10'h004
`define USBD_TX_FIFO_DEPTH 16

`endif

// File: verification/usbd_far_model.sv
// serial engine and endpoint buffer model facing the usb device register port
`default_nettype none
`include "usbd_regs.svh"
module usbd_far_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_phase,
    input wire logic [7:0] cmd_code_wdata,
    output logic cmd_done,
    output logic result_valid,
    output logic [7:0] result_data,
    input wire logic rx_len_req,
    input wire logic rx_word_req,
    output logic rx_len_valid,
    output usbd_pkg::usbd_len_t rx_len_bytes,
    output logic rx_len_ok,
    output logic rx_word_valid,
    output logic [31:0] rx_word_data,
    output logic tx_word_ready,
    input wire usbd_pkg::usbd_len_t pkt_len,
    input wire logic pkt_ok,
    input wire logic tx_stall
);
    import usbd_pkg::*;
    logic [1:0] cnt;
    logic len_dly;
    logic [7:0] base;
    wire logic fin;
    assign fin = cmd_valid && cnt == 2'h2;
    // released data lines toggle so a stale value is never mistaken for a fresh one
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cnt <= 2'h0;
            cmd_done <= 1'b0;
            result_valid <= 1'b0;
            result_data <= 8'h00;
        end else begin
            cnt <= (cmd_valid && !cmd_done) ? cnt + 2'h1 : 2'h0;
            cmd_done <= fin && !cmd_done;
            result_valid <= fin && !cmd_done && cmd_phase == `USBD_PHASE_READ;
            result_data <= (fin && !cmd_done) ? ~cmd_code_wdata : ~result_data;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            len_dly <= 1'b0;
            rx_len_valid <= 1'b0;
            rx_len_bytes <= 10'h000;
            rx_len_ok <= 1'b0;
            rx_word_valid <= 1'b0;
            rx_word_data <= 32'h0;
            base <= 8'h10;
            tx_word_ready <= 1'b0;
        end else begin
            len_dly <= rx_len_req;
            rx_len_valid <= len_dly;
            rx_len_bytes <= len_dly ? pkt_len : ~rx_len_bytes;
            rx_len_ok <= len_dly ? pkt_ok : ~rx_len_ok;
            rx_word_valid <= rx_word_req;
            rx_word_data <= rx_word_req ? {base + 8'h03, base + 8'h02, base + 8'h01, base}
                : ~rx_word_data;
            base <= rx_len_req ? 8'h10 : (rx_word_req ? base + 8'h04 : base);
            tx_word_ready <= !tx_stall;
        end
    end
endmodule : usbd_far_model
`default_nettype wire

// File: verification/usbd_port_asserts.sv
// concurrent checks on the usb device register port
`default_nettype none
`include "usbd_regs.svh"
module usbd_port_asserts (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_phase,
    input wire logic [7:0] cmd_code_wdata,
    input wire logic cmd_done,
    input wire logic result_valid,
    input wire logic [7:0] result_data,
    input wire logic rx_word_req,
    input wire logic rx_len_valid,
    input wire usbd_pkg::usbd_len_t rx_len_bytes,
    input wire logic tx_word_valid,
    input wire logic tx_word_ready,
    input wire logic [31:0] tx_word_data,
    input wire usbd_pkg::usbd_ep_t tx_word_ep
);
    import usbd_pkg::*;
    wire logic cmd_wr;
    wire logic ph_ok;
    wire logic res_rd;
    assign cmd_wr = reg_write && reg_addr == `USBD_CMD_ADDR;
    assign ph_ok = reg_wdata[15:8] inside {8'h01, 8'h02, 8'h05};
    assign res_rd = reg_read && reg_addr == `USBD_RESULT_ADDR;
    // last byte the engine handed back, so every result read is checked
    logic [7:0] res_shadow;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            res_shadow <= 8'h00;
        end else if (result_valid) begin
            res_shadow <= result_data;
        end
    end
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    a_cmd_forward: assert property (
        cmd_wr && ph_ok |=> cmd_valid && cmd_phase == $past(reg_wdata[15:8])
        && cmd_code_wdata == $past(reg_wdata[23:16])) else $error("command not forwarded");
    a_cmd_held: assert property (
        cmd_valid && !cmd_done |=> cmd_valid) else $error("command dropped early");
    a_cmd_release: assert property (
        cmd_valid && cmd_done && !cmd_wr |=> !cmd_valid) else $error("command not released");
    a_bad_phase: assert property (
        cmd_wr && !ph_ok && !cmd_valid |=> !cmd_valid) else $error("unknown phase forwarded");
    a_cmd_write_only: assert property (
        reg_read && reg_addr == `USBD_CMD_ADDR |=> reg_rdata == 32'h0)
        else $error("command word readable");
    a_result_byte: assert property (
        res_rd |=> reg_rdata == {24'h000000, $past(res_shadow)}) else $error("result byte wrong");
    a_rx_fetch_word: assert property (
        rx_len_valid && rx_len_bytes != 10'h0 |=> rx_word_req) else $error("no word fetch");
    a_rx_empty_pkt: assert property (
        rx_len_valid && rx_len_bytes == 10'h0 |=> !rx_word_req [*3])
        else $error("fetch on empty packet");
    a_tx_word_hold: assert property (
        tx_word_valid && !tx_word_ready |=> tx_word_valid && $stable(tx_word_data)
        && $stable(tx_word_ep)) else $error("tx word changed while stalled");
    c_cmd_done: cover property (cmd_valid && cmd_done);
    c_result: cover property (result_valid ##[1:40] res_rd);
    c_tx_stall: cover property (tx_word_valid && !tx_word_ready [*2] ##1 tx_word_ready);
endmodule : usbd_port_asserts
`default_nettype wire

// File: verification/usbd_port_tb.sv
// self-checking bench for the usb device register port
`default_nettype none
`include "usbd_regs.svh"
module usbd_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import usbd_pkg::*;
    localparam int D = 4;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [31:0] reg_addr = 32'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata, rx_word_data, tx_word_data, d;
    logic [7:0] cmd_phase, cmd_code_wdata, result_data;
    logic cmd_valid, cmd_done, result_valid, rx_len_req, rx_word_req, rx_len_valid;
    logic rx_len_ok, rx_word_valid, tx_word_valid, tx_word_ready;
    usbd_ep_t rx_ep, tx_word_ep;
    usbd_len_t rx_len_bytes;
    usbd_len_t pkt_len = 10'h000;
    logic pkt_ok = 1'b0;
    logic tx_stall = 1'b0;
    int miscompares = 0;
    int checks = 0;
    int n, left;
    logic [35:0] txq[$];
    logic [31:0] rmap[8] = '{32'h40020000, 32'h40020010, 32'h40020014, 32'h40020018,
        32'h40020020, 32'h40020024, 32'h40020028, 32'h40020030};
    logic [7:0] ph[4] = '{8'h01, 8'h02, 8'h05, 8'h03};
    usbd_len_t plen[3] = '{10'h00A, 10'h004, 10'h000};
    logic pok[3] = '{1'b1, 1'b0, 1'b1};
    usbd_port #(.FIFO_DEPTH(D)) DUT (.*);
    usbd_far_model u_far (.*);
    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (nrst && tx_word_valid === 1'b1 && tx_word_ready === 1'b1) begin
            txq.push_back({tx_word_ep, tx_word_data});
        end
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        tally_and_finish();
    end
    // ------------------------------------------------
    // bus tasks
    // ------------------------------------------------
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] e);
        checks++;
        if (seen !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", s, e, seen);
        end
    endtask : chk
    task automatic rchk(input string s, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(s, v, e);
    endtask : rchk
    task automatic wait_bit(input int b);
        for (int t = 0; t < 40; t++) begin
            rd(`USBD_STATUS_ADDR, d);
            if (d[b] === 1'b1) return;
        end
        miscompares++;
        $display("Error status bit %0d expected 1 seen 0", b);
        tally_and_finish();
    endtask : wait_bit
    task automatic wait_q(input int m);
        for (int t = 0; t < 200; t++) begin
            if (txq.size() >= m) return;
            @(posedge ref_clk);
        end
        miscompares++;
        $display("Error tx words expected %0d seen %0d", m, txq.size());
        tally_and_finish();
    endtask : wait_q
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        foreach (rmap[i]) rchk("reset value", rmap[i], 32'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(`USBD_CMD_ADDR, {8'h00, 8'hA0 + 8'(i), ph[i], 8'h00});
            #1;
            if (i < 3) begin
                chk("cmd phase", {24'h0, cmd_phase}, {24'h0, ph[i]});
                chk("cmd code", {24'h0, cmd_code_wdata}, 32'h000000A0 + 32'(i));
            end else begin
                chk("cmd held back", {31'h0, cmd_valid}, 32'h0);
            end
            wait_bit(10);
            if (i == 1) begin
                wait_bit(11);
                rd(`USBD_RESULT_ADDR, d);
                chk("result byte", d & 32'hFF, 32'h0000005E);
            end
            rchk("cmd readback", `USBD_CMD_ADDR, 32'h0);
            wr(`USBD_CLEAR_ADDR, 32'h00000C00);
        end
        $display("test commands done");
        for (int p = 0; p < 3; p++) begin
            wr(`USBD_CLEAR_ADDR, 32'h00001000);
            pkt_len <= plen[p];
            pkt_ok <= pok[p];
            wr(`USBD_CTRL_ADDR, 32'h0000000D);
            repeat (5) @(posedge ref_clk);
            chk("rx endpoint", {28'h0, rx_ep}, 32'h3);
            rchk("rx length", `USBD_RXLEN_ADDR, {21'h0, pok[p], plen[p]});
            for (int w = 0; w < (plen[p] + 10'h3) / 10'h4; w++) begin
                repeat (3) @(posedge ref_clk);
                rchk("rx word", `USBD_RXDATA_ADDR, {8'(19 + 4 * w), 8'(18 + 4 * w),
                    8'(17 + 4 * w), 8'(16 + 4 * w)});
                left = plen[p] > 4 * (w + 1) ? plen[p] - 4 * (w + 1) : 0;
                rchk("rx left", `USBD_RXLEN_ADDR, {21'h0, pok[p], 10'(left)});
            end
            rd(`USBD_STATUS_ADDR, d);
            chk("rx done", {31'h0, d[12]}, 32'h1);
            rchk("rx enable off", `USBD_CTRL_ADDR, 32'h0000000C);
        end
        $display("test receive done");
        tx_stall <= 1'b1;
        wr(`USBD_TXLEN_ADDR, 32'(4 * (D + 3)));
        wr(`USBD_CTRL_ADDR, 32'h00000016);
        n = 0;
        for (int k = 0; k < D + 3; k++) begin
            wr(`USBD_TXDATA_ADDR, 32'hC0DE0000 + 32'(k));
            n++;
            rd(`USBD_STATUS_ADDR, d);
            if (d[16] === 1'b1) break;
        end
        chk("tx accepted", 32'(n), 32'(D + 1));
        wr(`USBD_TXDATA_ADDR, 32'hDEAD0000);
        rchk("tx left full", `USBD_TXLEN_ADDR, 32'h00000008);
        tx_stall <= 1'b0;
        wait_q(n);
        for (int k = n; k < n + 2; k++) wr(`USBD_TXDATA_ADDR, 32'hC0DE0000 + 32'(k));
        rchk("tx left end", `USBD_TXLEN_ADDR, 32'h0);
        rd(`USBD_STATUS_ADDR, d);
        chk("tx done", {31'h0, d[13]}, 32'h1);
        rchk("tx enable off", `USBD_CTRL_ADDR, 32'h00000014);
        wait_q(n + 2);
        foreach (txq[k]) chk("tx word", txq[k][31:0], 32'hC0DE0000 + 32'(k));
        foreach (txq[k]) chk("tx endpoint", {28'h0, txq[k][35:32]}, 32'h5);
        $display("test transmit done");
        tally_and_finish();
    end
endmodule : usbd_port_tb
bind usbd_port usbd_port_asserts u_chk (.*);
`default_nettype wire
